/* rtl/ims_ctrl.v */
// Byte-oriented two-wire serial controller, master and slave, one instance.
// Assumes pin inputs are synchronous to clk_sys and a pull-up on both lines.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defs.vh"

module ims_ctrl (
   input wire clk_sys,
   input wire rst,
   input wire [1:0] regAddr,
   input wire regWr,
   input wire regRd,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata_q,
   output reg irqOut_q,
   input wire sdaIn,
   output reg sdaOut_q,
   output reg sdaOe_q,
   input wire sclIn,
   output reg sclOut_q,
   output reg sclOe_q,
   input wire gpioSdaOut,
   input wire gpioSdaOe,
   input wire gpioSclOut,
   input wire gpioSclOe
);
   localparam M_IDLE = 3'h0;
   localparam M_ST = 3'h1;
   localparam M_BIT = 3'h2;
   localparam M_RS1 = 3'h3;
   localparam M_RS2 = 3'h4;
   localparam M_SP1 = 3'h5;
   localparam M_SP2 = 3'h6;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [2:0] divSel_q;
   reg en_q;
   reg beginReq_q;
   reg stopReq_q;
   reg ownMatch_q;
   reg ackEn_q;
   reg [7:0] ownId_q;
   reg [7:0] sh_q;
   reg gc_q;
   reg stopF_q;
   reg irq_q;
   reg tx_q;
   reg busy_q;
   reg lost_q;
   reg lostCur_q;
   reg nack_q;
   reg slave_q;
   reg master_q;
   reg [3:0] bitCnt_q;
   reg addrPh_q;
   reg bound_q;
   reg ackOut_q;
   reg sdaDrv_q;
   reg sclDrv_q;
   reg [2:0] mst_q;
   reg sclP_q;
   reg sdaP_q;

   wire tick;
   wire bufInReady;
   wire bufOutValid;
   wire [7:0] bufOutData;
   wire [7:0] statusVal;
   wire wrCtrl = regWr & (regAddr == `IMS_REG_CTRL);
   wire wrData = regWr & (regAddr == `IMS_REG_DATA);
   wire wrOwn = regWr & (regAddr == `IMS_REG_OWN);
   wire rdStat = regRd & (regAddr == `IMS_REG_STAT);
   wire rdData = regRd & (regAddr == `IMS_REG_DATA);
   wire sclRise = sclIn & ~sclP_q;
   wire sclFall = ~sclIn & sclP_q;
   wire startDet = sclIn & sclP_q & sdaP_q & ~sdaIn;
   wire stopDet = sclIn & sclP_q & ~sdaP_q & sdaIn;
   wire hold = irq_q | ~bufInReady;
   wire atBound = bound_q & (bitCnt_q == 4'h0);
   wire ownHit = (sh_q[7:1] == ownId_q[7:1]);
   wire gcHit = (sh_q[7:1] == 7'h00) & ownId_q[0];
   wire byteEnd = sclRise & busy_q & (bitCnt_q == 4'h8);
   wire irqEvt = master_q | lostCur_q | (slave_q & ~addrPh_q)
      | (addrPh_q & ackOut_q & ~master_q);
   wire push = byteEnd & irqEvt & ~tx_q;

   assign statusVal = {gc_q, stopF_q, irq_q, tx_q, busy_q & ~master_q,
      lost_q, nack_q, slave_q};

   // -------------------------------------------------------------------------
   // Serial clock divider and receive buffer
   // -------------------------------------------------------------------------
   ims_clkdiv u_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(en_q),
      .divSel(divSel_q),
      .tick(tick)
   );

   ims_buf2 u_buf (
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(~en_q),
      .inValid(push),
      .inReady(bufInReady),
      .inData(sh_q),
      .outValid(bufOutValid),
      .outReady(rdData),
      .outData(bufOutData)
   );

   // -------------------------------------------------------------------------
   // Register port and byte engine
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         divSel_q <= 3'h0;
         en_q <= 1'b0;
         beginReq_q <= 1'b0;
         stopReq_q <= 1'b0;
         ownMatch_q <= 1'b0;
         ackEn_q <= 1'b0;
         ownId_q <= `IMS_RST_OWN;
         sh_q <= `IMS_RST_DATA;
         gc_q <= 1'b0;
         stopF_q <= 1'b0;
         irq_q <= 1'b0;
         tx_q <= 1'b0;
         busy_q <= 1'b0;
         lost_q <= 1'b0;
         lostCur_q <= 1'b0;
         nack_q <= 1'b0;
         slave_q <= 1'b0;
         master_q <= 1'b0;
         bitCnt_q <= 4'h0;
         addrPh_q <= 1'b0;
         bound_q <= 1'b0;
         ackOut_q <= 1'b0;
         sdaDrv_q <= 1'b0;
         sclDrv_q <= 1'b0;
         mst_q <= M_IDLE;
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclP_q <= sclIn;
         sdaP_q <= sdaIn;
         if (wrCtrl) begin
            divSel_q <= {regWdata[`IMS_C_DIVHI], regWdata[`IMS_C_DIVMID],
               regWdata[`IMS_C_DIVLO]};
            en_q <= regWdata[`IMS_C_EN];
            beginReq_q <= regWdata[`IMS_C_BEGIN];
            stopReq_q <= regWdata[`IMS_C_END];
            ownMatch_q <= regWdata[`IMS_C_OWNM];
            ackEn_q <= regWdata[`IMS_C_ACK];
         end
         if (wrOwn) begin
            ownId_q <= regWdata;
         end
         if (wrData) begin
            sh_q <= regWdata;
         end
         if (rdStat) begin
            irq_q <= 1'b0;
         end
         if (!en_q) begin
            // Disabled: bus state dropped except lostCur_q and the gc, stop, irq, lost and nack flags, both lines released.
            tx_q <= 1'b0;
            busy_q <= 1'b0;
            slave_q <= 1'b0;
            master_q <= 1'b0;
            bitCnt_q <= 4'h0;
            addrPh_q <= 1'b0;
            bound_q <= 1'b0;
            ackOut_q <= 1'b0;
            sdaDrv_q <= 1'b0;
            sclDrv_q <= 1'b0;
            mst_q <= M_IDLE;
         end else begin
            if (startDet) begin
               busy_q <= 1'b1;
               bitCnt_q <= 4'h0;
               addrPh_q <= 1'b1;
               bound_q <= 1'b0;
               slave_q <= 1'b0;
               gc_q <= 1'b0;
               stopF_q <= 1'b0;
               tx_q <= master_q;
            end
            if (stopDet) begin
               busy_q <= 1'b0;
               stopF_q <= 1'b1;
               stopReq_q <= 1'b0;
               master_q <= 1'b0;
               slave_q <= 1'b0;
               tx_q <= 1'b0;
               addrPh_q <= 1'b0;
               bound_q <= 1'b0;
               if (slave_q) begin
                  irq_q <= 1'b1;
               end
            end
            if (sclRise && busy_q && bitCnt_q != 4'h8) begin
               sh_q <= {sh_q[6:0], sdaIn};
               bitCnt_q <= bitCnt_q + 4'h1;
               bound_q <= 1'b0;
               if (master_q && tx_q && !sdaDrv_q && !sdaIn) begin
                  lost_q <= 1'b1;
                  lostCur_q <= 1'b1;
                  master_q <= 1'b0;
                  tx_q <= 1'b0;
               end
            end
            if (byteEnd) begin
               nack_q <= sdaIn;
               bitCnt_q <= 4'h0;
               addrPh_q <= 1'b0;
               bound_q <= 1'b1;
               lostCur_q <= 1'b0;
               if (irqEvt) begin
                  irq_q <= 1'b1;
               end
               if (addrPh_q && master_q) begin
                  tx_q <= ~sh_q[0];
               end else if (addrPh_q && ackOut_q) begin
                  slave_q <= 1'b1;
                  tx_q <= sh_q[0];
                  ownMatch_q <= 1'b1;
               end
            end
            if (sclFall && busy_q) begin
               if (bitCnt_q != 4'h8) begin
                  ackOut_q <= 1'b0;
               end else if (addrPh_q) begin
                  ackOut_q <= ackEn_q & ~master_q & (ownHit | gcHit);
                  gc_q <= ackEn_q & ~master_q & gcHit;
               end else begin
                  ackOut_q <= ackEn_q & ~tx_q & (master_q | slave_q);
               end
            end
            if (!sclIn) begin
               if (tx_q && bitCnt_q != 4'h8) begin
                  sdaDrv_q <= ~sh_q[7];
               end else begin
                  sdaDrv_q <= ackOut_q;
               end
            end
            if (mst_q == M_IDLE && !master_q) begin
               // Selected slave stretches the clock until the byte is serviced.
               sclDrv_q <= slave_q & atBound & hold & (~sclIn | sclDrv_q);
            end
            // Master sequencer; its line drives override the byte engine.
            case (mst_q)
               M_IDLE: begin
                  if (beginReq_q && !busy_q && sclIn && sdaIn && tick) begin
                     sdaDrv_q <= 1'b1;
                     master_q <= 1'b1;
                     beginReq_q <= 1'b0;
                     lost_q <= 1'b0;
                     mst_q <= M_ST;
                  end
               end
               M_ST: begin
                  sdaDrv_q <= 1'b1;
                  if (tick) begin
                     sclDrv_q <= 1'b1;
                     mst_q <= M_BIT;
                  end
               end
               M_BIT: begin
                  if (!master_q) begin
                     sclDrv_q <= 1'b0;
                     mst_q <= M_IDLE;
                  end else if (tick) begin
                     if (sclDrv_q) begin
                        if (atBound && hold) begin
                           sclDrv_q <= 1'b1;
                        end else if (atBound && beginReq_q) begin
                           mst_q <= M_RS1;
                        end else if (atBound && stopReq_q) begin
                           mst_q <= M_SP1;
                        end else begin
                           sclDrv_q <= 1'b0;
                        end
                     end else if (sclIn) begin
                        sclDrv_q <= 1'b1;
                     end
                  end
               end
               M_RS1: begin
                  sdaDrv_q <= 1'b0;
                  if (tick) begin
                     sclDrv_q <= 1'b0;
                     mst_q <= M_RS2;
                  end
               end
               M_RS2: begin
                  if (!sclIn) begin
                     sdaDrv_q <= 1'b0;
                  end else if (tick) begin
                     sdaDrv_q <= 1'b1;
                     beginReq_q <= 1'b0;
                     lost_q <= 1'b0;
                     mst_q <= M_ST;
                  end
               end
               M_SP1: begin
                  sdaDrv_q <= 1'b1;
                  if (tick) begin
                     sclDrv_q <= 1'b0;
                     mst_q <= M_SP2;
                  end
               end
               M_SP2: begin
                  if (!sclIn) begin
                     sdaDrv_q <= 1'b1;
                  end else if (tick) begin
                     sdaDrv_q <= 1'b0;
                     mst_q <= M_IDLE;
                  end
               end
               default: begin
                  mst_q <= M_IDLE;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read data and pins
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regRdata_q <= 8'h00;
         irqOut_q <= 1'b0;
         sdaOut_q <= 1'b0;
         sdaOe_q <= 1'b0;
         sclOut_q <= 1'b0;
         sclOe_q <= 1'b0;
      end else begin
         irqOut_q <= irq_q;
         if (regRd) begin
            case (regAddr)
               `IMS_REG_CTRL: regRdata_q <= {divSel_q[2], en_q, beginReq_q, stopReq_q,
                  ownMatch_q, ackEn_q, divSel_q[1:0]};
               `IMS_REG_STAT: regRdata_q <= statusVal;
               `IMS_REG_DATA: regRdata_q <= bufOutValid ? bufOutData : sh_q;
               default: regRdata_q <= ownId_q;
            endcase
         end
         // Disabled port hands its pins to the general-purpose port.
         sdaOut_q <= en_q ? 1'b0 : gpioSdaOut;
         sdaOe_q <= en_q ? sdaDrv_q : gpioSdaOe;
         sclOut_q <= en_q ? 1'b0 : gpioSclOut;
         sclOe_q <= en_q ? sclDrv_q : gpioSclOe;
      end
   end
endmodule
`default_nettype wire

/* inc/ims_defs.vh */
// Constants of the two-wire serial controller: register indices, bit positions,
// reset values and serial clock half-period counts.
// Assumes a 200 MHz system clock and an 8-bit register port with a 2-bit index.
`ifndef IMS_DEFS_VH
`define IMS_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IMS_REG_CTRL 2'h0
`define IMS_REG_STAT 2'h1
`define IMS_REG_DATA 2'h2
`define IMS_REG_OWN 2'h3

// ----------------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------------
`define IMS_C_DIVHI 7
`define IMS_C_EN 6
`define IMS_C_BEGIN 5
`define IMS_C_END 4
`define IMS_C_OWNM 3
`define IMS_C_ACK 2
`define IMS_C_DIVMID 1
`define IMS_C_DIVLO 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IMS_RST_CTRL 8'h00
`define IMS_RST_OWN 8'h00
`define IMS_RST_DATA 8'h00

// ----------------------------------------------------------------------------
// Half of each serial clock divisor (16, 24, 30, 60, 120, 240, 480, 960)
// ----------------------------------------------------------------------------
`define IMS_HALF_0 10'h008
`define IMS_HALF_1 10'h00c
`define IMS_HALF_2 10'h00f
`define IMS_HALF_3 10'h01e
`define IMS_HALF_4 10'h03c
`define IMS_HALF_5 10'h078
`define IMS_HALF_6 10'h0f0
`define IMS_HALF_7 10'h1e0

`endif

/* rtl/ims_clkdiv.v */
// Serial clock divider: one-cycle tick at each half period of the bus clock.
// Assumes the select code is stable while the controller is mastering.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defs.vh"

module ims_clkdiv (
   input wire clk_sys,
   input wire rst,
   input wire enable,
   input wire [2:0] divSel,
   output reg tick
);
   reg [9:0] cnt_q;
   reg [9:0] half;

   always @* begin
      case (divSel)
         3'h0: half = `IMS_HALF_0;
         3'h1: half = `IMS_HALF_1;
         3'h2: half = `IMS_HALF_2;
         3'h3: half = `IMS_HALF_3;
         3'h4: half = `IMS_HALF_4;
         3'h5: half = `IMS_HALF_5;
         3'h6: half = `IMS_HALF_6;
         default: half = `IMS_HALF_7;
      endcase
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 10'h000;
         tick <= 1'b0;
      end else if (!enable || cnt_q + 10'h001 >= half) begin
         cnt_q <= 10'h000;
         tick <= enable;
      end else begin
         cnt_q <= cnt_q + 10'h001;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* rtl/ims_buf2.v */
// Two-entry first-in first-out buffer with valid and ready on both sides.
// Assumes push and pop are single-cycle handshakes on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ims_buf2 (
   input wire clk_sys,
   input wire rst,
   input wire flush,
   input wire inValid,
   output wire inReady,
   input wire [7:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [7:0] outData
);
   reg [7:0] mem_q [0:1];
   reg [1:0] cnt_q;
   reg rdPtr_q;
   reg wrPtr_q;
   wire push;
   wire pop;

   assign inReady = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData = mem_q[rdPtr_q];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always @(posedge clk_sys) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
      end else if (flush) begin
         cnt_q <= 2'h0;
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
      end else begin
         if (push) begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (pop) begin
            rdPtr_q <= ~rdPtr_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/ims_ctrl_sva.sv */
// Checker for the two-wire serial controller, bound to its top module.
// Assumes the register indices and control bit positions of ims_defs.vh.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defs.vh"
module ims_ctrl_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [1:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata_q,
   input wire logic irqOut_q,
   input wire logic sdaIn,
   input wire logic sdaOut_q,
   input wire logic sdaOe_q,
   input wire logic sclIn,
   input wire logic sclOut_q,
   input wire logic sclOe_q,
   input wire logic gpioSdaOut,
   input wire logic gpioSdaOe,
   input wire logic gpioSclOut,
   input wire logic gpioSclOe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic enable_q;
   logic [7:0] own_q;
   logic sdaPrev_q;
   logic sclPrev_q;
   logic [3:0] stopAge_q;
   // Tracks the port enable and own address as written, and the age of the last stop.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enable_q <= 1'b0;
         own_q <= `IMS_RST_OWN;
         sdaPrev_q <= 1'b1;
         sclPrev_q <= 1'b1;
         stopAge_q <= 4'h0;
      end else begin
         if (regWr && regAddr == `IMS_REG_CTRL) enable_q <= regWdata[`IMS_C_EN];
         if (regWr && regAddr == `IMS_REG_OWN) own_q <= regWdata;
         sdaPrev_q <= sdaIn;
         sclPrev_q <= sclIn;
         if (enable_q && sclPrev_q && sclIn && !sdaPrev_q && sdaIn) stopAge_q <= 4'h1;
         else if (sclPrev_q && sclIn && sdaPrev_q && !sdaIn) stopAge_q <= 4'h0;
         else if (stopAge_q != 4'h0 && stopAge_q != 4'hf) stopAge_q <= stopAge_q + 4'h1;
      end
   end
   sequence startByDut;
      enable_q && $past(enable_q) && sclIn && $rose(sdaOe_q);
   endsequence
   sequence sclFollows;
      ##[1:600] $rose(sclOe_q);
   endsequence
   AST_GPIO_SDA: assert property (!enable_q && !$past(enable_q) && !$past(rst) |->
      sdaOe_q == $past(gpioSdaOe) && sdaOut_q == $past(gpioSdaOut)) else $error("sda not gpio");
   AST_GPIO_SCL: assert property (!enable_q && !$past(enable_q) && !$past(rst) |->
      sclOe_q == $past(gpioSclOe) && sclOut_q == $past(gpioSclOut)) else $error("scl not gpio");
   AST_SDA_LOW: assert property (enable_q && $past(enable_q) |-> !sdaOut_q)
      else $error("sda driven high");
   AST_SCL_LOW: assert property (enable_q && $past(enable_q) |-> !sclOut_q)
      else $error("scl driven high");
   AST_IRQ_CLR: assert property (regRd && regAddr == `IMS_REG_STAT |-> ##2 !irqOut_q)
      else $error("irq kept after status read");
   AST_IRQ_COPY: assert property (regRd && regAddr == `IMS_REG_STAT |=> regRdata_q[5] == irqOut_q)
      else $error("irq pin differs from status");
   AST_OWN_READ: assert property (regRd && regAddr == `IMS_REG_OWN |=> regRdata_q == own_q)
      else $error("own address readback wrong");
   AST_START: assert property (startByDut |-> sclFollows)
      else $error("no clock after start");
   AST_STOP_FLAG: assert property (regRd && regAddr == `IMS_REG_STAT && stopAge_q >= 4'h6 |=>
      regRdata_q[6]) else $error("stop flag missing");
endmodule
bind ims_ctrl ims_ctrl_sva ims_ctrl_sva_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
   .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata_q(regRdata_q),
   .irqOut_q(irqOut_q), .sdaIn(sdaIn), .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q), .sclIn(sclIn),
   .sclOut_q(sclOut_q), .sclOe_q(sclOe_q), .gpioSdaOut(gpioSdaOut), .gpioSdaOe(gpioSdaOe),
   .gpioSclOut(gpioSclOut), .gpioSclOe(gpioSclOe));
`default_nettype wire

/* bench/ims_partner.sv */
// Far side of the two-wire bus: a slave that captures one byte per frame,
// and a master driven by tasks. Assumes pull-ups resolved in the bench.
`timescale 1ns/1ps
`default_nettype none
module ims_partner (
   input wire logic clk,
   input wire logic sdaLine,
   input wire logic sclLine,
   output logic sdaPull,
   output logic sclPull
);
   logic slaveOn = 0;
   logic ackOn = 0;
   logic [7:0] rxByte = 0;
   int period = 0;
   int nStops = 0;
   real t0 = 0.0;
   initial sdaPull = 0;
   initial sclPull = 0;
   always @(posedge sdaLine) if (sclLine) nStops++;
   initial forever begin : rxFrame
      int i;
      @(negedge sdaLine);
      if (slaveOn && sclLine) begin
         for (i = 0; i < 8; i++) begin
            @(posedge sclLine);
            rxByte = {rxByte[6:0], sdaLine};
            if (i == 1) t0 = $realtime;
            if (i == 2) period = int'(($realtime - t0) / 5.0);
         end
         @(negedge sclLine);
         #1 sdaPull = ackOn;
         @(negedge sclLine);
         #1 sdaPull = 0;
      end
   end
   task automatic halfWait();
      repeat (20) @(posedge clk);
   endtask
   // Releases the clock and waits while a slave stretches it, then holds it high.
   task automatic sclRise();
      int n;
      n = 0;
      #1 sclPull = 0;
      while (sclLine !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      halfWait();
   endtask
   task automatic mBit(input logic b);
      repeat (4) @(posedge clk);
      #1 sdaPull = !b;
      halfWait();
      sclRise();
      #1 sclPull = 1;
   endtask
   task automatic mStart();
      #1 sdaPull = 1;
      halfWait();
      #1 sclPull = 1;
   endtask
   task automatic mByte(input logic [7:0] b, output logic ack);
      int i;
      for (i = 7; i >= 0; i--) mBit(b[i]);
      repeat (4) @(posedge clk);
      #1 sdaPull = 0;
      halfWait();
      sclRise();
      ack = sdaLine;
      #1 sclPull = 1;
   endtask
   task automatic mStop();
      repeat (4) @(posedge clk);
      #1 sdaPull = 1;
      halfWait();
      sclRise();
      #1 sdaPull = 0;
      halfWait();
   endtask
endmodule
`default_nettype wire

/* bench/ims_ctrl_bench.sv */
// Testbench of the two-wire serial controller with a bus partner.
// Assumes open-drain lines with pull-ups, resolved here from all enables.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defs.vh"
module ims_ctrl_bench;
   logic clk_sys = 0;
   logic rst = 1;
   logic [1:0] regAddr = 0;
   logic regWr = 0;
   logic regRd = 0;
   logic [7:0] regWdata = 0;
   logic gSdaOut = 0;
   logic gSdaOe = 0;
   logic gSclOut = 0;
   logic gSclOe = 0;
   wire [7:0] regRdata_q;
   wire irqOut_q, sdaOut_q, sdaOe_q, sclOut_q, sclOe_q, pSda, pScl;
   wire sdaLine = !((sdaOe_q & !sdaOut_q) | pSda);
   wire sclLine = !((sclOe_q & !sclOut_q) | pScl);
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int i, n, k;
   logic [7:0] rd, rd2;
   logic ack;
   logic [7:0] divs [3] = '{8'h10, 8'h18, 8'h1e};
   logic [7:0] foreign [2] = '{8'h20, 8'h00};
   initial forever #2.5 clk_sys = !clk_sys;
   ims_ctrl ims_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWr(regWr),
      .regRd(regRd), .regWdata(regWdata), .regRdata_q(regRdata_q), .irqOut_q(irqOut_q),
      .sdaIn(sdaLine), .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q), .sclIn(sclLine),
      .sclOut_q(sclOut_q), .sclOe_q(sclOe_q), .gpioSdaOut(gSdaOut), .gpioSdaOe(gSdaOe),
      .gpioSclOut(gSclOut), .gpioSclOe(gSclOe));
   ims_partner ims_partner_inst (.clk(clk_sys), .sdaLine(sdaLine), .sclLine(sclLine),
      .sdaPull(pSda), .sclPull(pScl));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic regW(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 regAddr = a;
      regWdata = d;
      regWr = 1;
      @(posedge clk_sys);
      #1 regWr = 0;
   endtask
   task automatic regR(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1 regAddr = a;
      regRd = 1;
      @(posedge clk_sys);
      #1 regRd = 0;
      d = regRdata_q;
   endtask
   task automatic waitIrq();
      int m;
      m = 0;
      while (irqOut_q !== 1'b1 && m < 20000) begin
         @(posedge clk_sys);
         m++;
      end
      check("irq", 8'h01, {7'h0, irqOut_q});
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rst = 0;
      regR(`IMS_REG_CTRL, rd);
      check("ctrl", `IMS_RST_CTRL, rd);
      regR(`IMS_REG_OWN, rd);
      check("own", `IMS_RST_OWN, rd);
      regR(`IMS_REG_STAT, rd);
      regW(`IMS_REG_STAT, 8'hff);
      regR(`IMS_REG_STAT, rd2);
      check("status", rd, rd2);
      gSdaOe = 1;
      gSclOe = 1;
      repeat (2) @(posedge clk_sys);
      #1 check("pins", 8'h0a, {4'h0, sdaOe_q, sdaOut_q, sclOe_q, sclOut_q});
      gSdaOe = 0;
      gSclOe = 0;
      repeat (2) @(posedge clk_sys);
      #1 check("pins", 8'h00, {4'h0, sdaOe_q, sdaOut_q, sclOe_q, sclOut_q});
      // Master transmitter at three divider codes; the last one is not acknowledged.
      regW(`IMS_REG_OWN, 8'ha4);
      for (i = 0; i < 3; i++) begin
         ims_partner_inst.slaveOn = 1;
         ims_partner_inst.ackOn = (i != 2);
         regW(`IMS_REG_DATA, 8'h74);
         regW(`IMS_REG_CTRL, {1'b0, 3'b110, 1'b0, 1'b1, i[1:0]});
         waitIrq();
         check("txbyte", 8'h74, ims_partner_inst.rxByte);
         check("period", divs[i], 8'(ims_partner_inst.period));
         regW(`IMS_REG_CTRL, {1'b0, 3'b101, 2'b01, i[1:0]});
         n = ims_partner_inst.nStops;
         regR(`IMS_REG_STAT, rd);
         check("txmode", 8'h10, rd & 8'h10);
         check("nack", (i == 2) ? 8'h02 : 8'h00, rd & 8'h03);
         for (k = 0; k < 5000 && ims_partner_inst.nStops == n; k++) @(posedge clk_sys);
         #1 check("stops", 8'h01, 8'(ims_partner_inst.nStops - n));
         repeat (8) @(posedge clk_sys);
         regR(`IMS_REG_STAT, rd);
         check("stopflag", 8'h40, rd & 8'h40);
         regR(`IMS_REG_CTRL, rd);
         check("endreq", 8'h00, rd & 8'h30);
      end
      // Slave receiver: foreign and general call addresses, then own address.
      ims_partner_inst.slaveOn = 0;
      regW(`IMS_REG_CTRL, 8'h44);
      for (i = 0; i < 2; i++) begin
         ims_partner_inst.mStart();
         ims_partner_inst.mByte(foreign[i], ack);
         check("foreign", 8'h01, {7'h0, ack});
         ims_partner_inst.mStop();
      end
      // General call with its enable bit set is acknowledged and flagged.
      regW(`IMS_REG_OWN, 8'ha5);
      ims_partner_inst.mStart();
      ims_partner_inst.mByte(8'h00, ack);
      check("gcack", 8'h00, {7'h0, ack});
      waitIrq();
      regR(`IMS_REG_STAT, rd);
      check("gcflag", 8'h80, rd & 8'h80);
      regR(`IMS_REG_DATA, rd);
      check("gcbyte", 8'h00, rd);
      ims_partner_inst.mStop();
      regR(`IMS_REG_STAT, rd);
      check("gcstop", 8'h40, rd & 8'h40);
      regW(`IMS_REG_CTRL, 8'h44);
      ims_partner_inst.mStart();
      ims_partner_inst.mByte(8'ha4, ack);
      check("ackaddr", 8'h00, {7'h0, ack});
      waitIrq();
      regR(`IMS_REG_CTRL, rd);
      check("ownmatch", 8'h08, rd & 8'h08);
      regR(`IMS_REG_DATA, rd);
      check("addrbyte", 8'ha4, rd);
      regW(`IMS_REG_CTRL, 8'h40);
      regR(`IMS_REG_CTRL, rd);
      check("ownclr", 8'h00, rd & 8'h08);
      regR(`IMS_REG_STAT, rd);
      check("slave", 8'h09, rd & 8'h19);
      check("busy", 8'h08, rd & 8'h08);
      ims_partner_inst.mByte(8'h5b, ack);
      check("nackdata", 8'h01, {7'h0, ack});
      waitIrq();
      regR(`IMS_REG_DATA, rd);
      check("rxbyte", 8'h5b, rd);
      regR(`IMS_REG_STAT, rd);
      ims_partner_inst.mStop();
      regR(`IMS_REG_STAT, rd);
      check("slvstop", 8'h40, rd & 8'h40);
      wrap_up();
   end
endmodule
`default_nettype wire
